/* File: src/adc_select_pkg.sv */
package adc_select_pkg;

	// register offsets (byte addresses on the plain port)
	localparam logic [7:0] comparator_control_status_off  = 8'h30;
	localparam logic [7:0] converter_input_select_off     = 8'h7c;
	localparam logic [7:0] converter_control_status_b_off = 8'h7b;
	localparam logic [7:0] digital_input_disable_one_off  = 8'h7f;

	// field positions
	localparam int module_select_pos     = 5;
	localparam int channel_select_lsb    = 0;
	localparam int channel_select_width  = 3;
	localparam int input_code_width      = 4;

	// reset values
	localparam logic [7:0] input_select_reset  = 8'h00;
	localparam logic [7:0] control_b_reset     = 8'h00;

	// writable masks: comparator enable and trigger codes are not kept
	localparam logic [7:0] input_select_mask   = 8'hef;
	localparam logic [7:0] control_b_mask      = 8'h20;

	// special input codes
	localparam logic [3:0] code_temp_sensor    = 4'h8;
	localparam logic [3:0] code_bandgap        = 4'he;
	localparam logic [3:0] code_ground         = 4'hf;

	// result format and bandgap scaling
	localparam int result_width                = 10;
	localparam int bandgap_millivolt           = 1100;
	localparam int reference_millivolt         = 3300;
	localparam logic [9:0] result_full_scale   = 10'h3ff;
	localparam logic [9:0] result_zero         = 10'h000;

	// result source selection
	typedef enum logic [3:0] {
		src_idle    = 4'b0001,
		src_convert = 4'b0010,
		src_fixed   = 4'b0100,
		src_done    = 4'b1000
	} seq_state_t;

endpackage

/* File: src/dual_adc_channel_select.sv */
`timescale 1ns/1ps
module dual_adc_channel_select
	import adc_select_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       conv_start,
	output logic            conv_busy,
	output logic            conv_done,
	output logic      [9:0] conv_result,
	output logic            adc1_start,
	output logic            adc2_start,
	output logic      [2:0] adc_channel,
	input  wire logic       adc1_done,
	input  wire logic [9:0] adc1_result,
	input  wire logic       adc2_done,
	input  wire logic [9:0] adc2_result
);

	////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] input_select;
	logic [7:0] control_b;
	logic [7:0] next_rdata;

	wire logic hit_input  = reg_addr == converter_input_select_off;
	wire logic hit_ctrl_b = reg_addr == converter_control_status_b_off;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			input_select <= input_select_reset;
			control_b    <= control_b_reset;
		end else if (reg_write) begin
			if (hit_input)
				input_select <= reg_wdata & input_select_mask;
			if (hit_ctrl_b)
				control_b <= reg_wdata & control_b_mask;
		end
	end

	assign next_rdata = !reg_read ? 8'h00 :
		hit_input  ? input_select :
		hit_ctrl_b ? control_b : 8'h00;

	// read data stand one cycle only
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////
	// decode

	wire logic       module_select_bit = control_b[module_select_pos];
	logic      [3:0] logical_input;
	logic            is_special;
	logic      [9:0] special_result;

	input_code_decoder u_decoder (
		.input_select      (input_select),
		.module_select_bit (module_select_bit),
		.logical_input     (logical_input),
		.is_special        (is_special),
		.special_result    (special_result)
	);

	////////////////////////////////////////////////////////////////////
	// conversion sequencer

	seq_state_t state;
	seq_state_t next_state;
	logic       active_module;
	logic [9:0] next_result;
	logic [9:0] held_special;

	// selection latched at start so a mid-conversion write cannot redirect
	wire logic take_start = conv_start && (state == src_idle);
	wire logic sel_done   = active_module ? adc2_done : adc1_done;
	wire logic [9:0] sel_result = active_module ? adc2_result : adc1_result;

	always_comb begin
		next_state = state;
		case (state)
			src_idle: begin
				if (conv_start)
					next_state = is_special ? src_fixed : src_convert;
			end
			src_convert: begin
				if (sel_done)
					next_state = src_done;
			end
			src_fixed:   next_state = src_done;
			src_done:    next_state = src_idle;
			default:     next_state = src_idle;
		endcase
	end

	// fixed result taken at start, so a write during the fixed cycle cannot alter it
	assign next_result = (state == src_fixed) ? held_special :
		(state == src_convert && sel_done) ? sel_result : conv_result;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state         <= src_idle;
			active_module <= 1'b0;
			adc_channel   <= 3'h0;
			conv_result   <= result_zero;
			held_special  <= result_zero;
		end else begin
			state       <= next_state;
			conv_result <= next_result;
			if (take_start) begin
				active_module <= logical_input[3];
				adc_channel   <= logical_input[2:0];
				held_special  <= special_result;
			end
		end
	end

	// start pulse steered to one module only
	assign adc1_start = take_start && !is_special && !logical_input[3];
	assign adc2_start = take_start && !is_special &&  logical_input[3];
	assign conv_busy  = state != src_idle;
	assign conv_done  = state == src_done;

	////////////////////////////////////////////////////////////////////
	// checks

	a_absent_read_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_read && (reg_addr == comparator_control_status_off ||
		reg_addr == digital_input_disable_one_off) |=> reg_rdata == 8'h00)
		else $error("absent register read nonzero");

	a_ctrl_mask_held: assert property (@(posedge sys_clk) disable iff (!rstn)
		(control_b & ~control_b_mask) == 8'h00)
		else $error("comparator bit stored");

	// write of select bit readable next
	a_module_bit_store: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_write && hit_ctrl_b |=> module_select_bit == $past(reg_wdata[module_select_pos]))
		else $error("module select not stored");

	// second module start only with bit set
	a_module_steer: assert property (@(posedge sys_clk) disable iff (!rstn)
		adc2_start |-> module_select_bit && !adc1_start)
		else $error("wrong module started");

	a_channel_forward: assert property (@(posedge sys_clk) disable iff (!rstn)
		take_start |=> adc_channel == $past(input_select[2:0]))
		else $error("channel field not forwarded");

	// start steps for the fixed paths
	sequence fixed_start_s;
		take_start && is_special;
	endsequence

	sequence ground_start_s;
		take_start && input_select[3:0] == code_ground;
	endsequence

	sequence bandgap_start_s;
		take_start && input_select[3:0] == code_bandgap;
	endsequence

	// one busy cycle, then the done pulse
	sequence fixed_path_s;
		conv_busy && !conv_done ##1 conv_done;
	endsequence

	a_fixed_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
		fixed_start_s |=> fixed_path_s)
		else $error("fixed path timing wrong");

	// ground gives zero two cycles later
	a_ground_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		ground_start_s |-> ##2 conv_done && conv_result == result_zero)
		else $error("ground code not zero");

	a_ground_no_start: assert property (@(posedge sys_clk) disable iff (!rstn)
		ground_start_s |-> !adc1_start && !adc2_start)
		else $error("ground code started a converter");

	// bandgap gives computed value, no converter start
	a_bandgap_value: assert property (@(posedge sys_clk) disable iff (!rstn)
		bandgap_start_s
		|-> !adc1_start && !adc2_start ##2 conv_done && conv_result == 10'h155)
		else $error("bandgap result wrong");

	// temperature code runs a real conversion on the chosen module
	a_temp_converts: assert property (@(posedge sys_clk) disable iff (!rstn)
		take_start && input_select[3:0] == code_temp_sensor
		|-> (module_select_bit ? adc2_start : adc1_start))
		else $error("temperature code not converted");

	a_single_start: assert property (@(posedge sys_clk) disable iff (!rstn)
		!(adc1_start && adc2_start))
		else $error("both modules started");

	a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	a_absent_write_none: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_write && !hit_input && !hit_ctrl_b |=> $stable(input_select) && $stable(control_b))
		else $error("absent write changed a register");

	a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_read && hit_ctrl_b |=> reg_rdata == $past(control_b))
		else $error("control b read wrong");

	a_input_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_read && hit_input |=> reg_rdata == $past(input_select))
		else $error("input register read wrong");

	a_input_store: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_write && hit_input |=> input_select == ($past(reg_wdata) & input_select_mask))
		else $error("input register not stored");

	a_input_mask_held: assert property (@(posedge sys_clk) disable iff (!rstn)
		(input_select & ~input_select_mask) == 8'h00)
		else $error("unkept input bit stored");

	// first module only with bit clear
	a_first_steer: assert property (@(posedge sys_clk) disable iff (!rstn)
		adc1_start |-> !module_select_bit && !adc2_start)
		else $error("first module wrongly started");

	a_choice_frozen: assert property (@(posedge sys_clk) disable iff (!rstn)
		conv_busy |=> $stable(active_module) && $stable(adc_channel))
		else $error("selection moved during conversion");

	a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rstn)
		conv_busy |-> !adc1_start && !adc2_start)
		else $error("start taken while busy");

	a_real_one_module: assert property (@(posedge sys_clk) disable iff (!rstn)
		take_start && !is_special |-> adc1_start != adc2_start)
		else $error("real conversion started no module");

	a_start_busy: assert property (@(posedge sys_clk) disable iff (!rstn)
		take_start |=> conv_busy)
		else $error("busy missing after start");

	a_answer_taken: assert property (@(posedge sys_clk) disable iff (!rstn)
		state == src_convert && sel_done |=> conv_done && conv_result == $past(sel_result))
		else $error("module answer not taken");

	a_bandgap_latched: assert property (@(posedge sys_clk) disable iff (!rstn)
		state == src_fixed |=> conv_result == $past(held_special))
		else $error("fixed result not the latched one");

	a_done_single: assert property (@(posedge sys_clk) disable iff (!rstn)
		conv_done |=> !conv_done && !conv_busy)
		else $error("done pulse too long");

	a_result_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
		!conv_done |-> $stable(conv_result))
		else $error("result changed without done");

	a_temp_not_special: assert property (@(posedge sys_clk) disable iff (!rstn)
		input_select[3:0] == code_temp_sensor |-> !is_special)
		else $error("temperature code treated as fixed");

endmodule // dual_adc_channel_select

/* File: src/input_code_decoder.sv */
`timescale 1ns/1ps
module input_code_decoder
	import adc_select_pkg::*;
(
	input  wire logic [7:0] input_select,
	input  wire logic       module_select_bit,
	output logic      [3:0] logical_input,
	output logic            is_special,
	output logic      [9:0] special_result
);

	// code to fixed result; bandgap rounded to nearest lsb
	function automatic logic [9:0] bandgap_code();
		return 10'((bandgap_millivolt * 1023 + reference_millivolt / 2) / reference_millivolt);
	endfunction

	wire logic [2:0] channel_select_field;
	wire logic [3:0] mux_code;

	assign channel_select_field = input_select[channel_select_lsb +: channel_select_width];
	assign mux_code             = input_select[input_code_width-1:0];

	// module bit times eight plus channel field
	assign logical_input = {module_select_bit, channel_select_field};

	// special code decode
	// bandgap and ground skip the converter; temp code converts as normal
	assign is_special     = (mux_code == code_bandgap) || (mux_code == code_ground);
	assign special_result = (mux_code == code_bandgap) ? bandgap_code() : result_zero;

endmodule // input_code_decoder

/* File: verif/adc_pair_model.sv */
`timescale 1ns/1ps
// two eight-input converter modules; the first answers fast, the second slowly
module adc_pair_model #(
	parameter int slow = 6
) (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       adc1_start,
	input  wire logic       adc2_start,
	input  wire logic [2:0] adc_channel,
	output logic            adc1_done,
	output logic            adc2_done,
	output logic      [9:0] adc1_result,
	output logic      [9:0] adc2_result
);
	logic [3:0] wait1;
	logic [3:0] wait2;
	logic [9:0] val1;
	logic [9:0] val2;
	// countdown per module; channel is read at done time, once it is latched
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wait1 <= 4'h0;
			wait2 <= 4'h0;
		end else begin
			wait1 <= adc1_start ? 4'h2 : ((wait1 != 4'h0) ? wait1 - 4'h1 : 4'h0);
			wait2 <= adc2_start ? 4'(slow) : ((wait2 != 4'h0) ? wait2 - 4'h1 : 4'h0);
		end
	end
	// result marks its module and channel; off the done cycle it shows garbage
	assign val1        = {4'h5, 3'h0, adc_channel};
	assign val2        = {4'ha, 3'h0, adc_channel};
	assign adc1_done   = (wait1 == 4'h1);
	assign adc2_done   = (wait2 == 4'h1);
	assign adc1_result = adc1_done ? val1 : ~val1;
	assign adc2_result = adc2_done ? val2 : ~val2;
endmodule // adc_pair_model

/* File: verif/test_dual_adc_channel_select.sv */
`timescale 1ns/1ps
module test_dual_adc_channel_select
	import adc_select_pkg::*;
;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_write = 1'b0;
	logic       reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic       conv_start = 1'b0;
	logic       conv_busy;
	logic       conv_done;
	logic [9:0] conv_result;
	logic       adc1_start;
	logic       adc2_start;
	logic [2:0] adc_channel;
	logic       adc1_done;
	logic       adc2_done;
	logic [9:0] adc1_result;
	logic [9:0] adc2_result;
	int         fails = 0;
	int         num_checks = 0;
	int         starts = 0;

	dual_adc_channel_select dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .conv_start(conv_start), .conv_busy(conv_busy),
		.conv_done(conv_done), .conv_result(conv_result), .adc1_start(adc1_start),
		.adc2_start(adc2_start), .adc_channel(adc_channel), .adc1_done(adc1_done),
		.adc1_result(adc1_result), .adc2_done(adc2_done), .adc2_result(adc2_result));
	adc_pair_model far (.sys_clk(sys_clk), .rstn(rstn), .adc1_start(adc1_start),
		.adc2_start(adc2_start), .adc_channel(adc_channel), .adc1_done(adc1_done),
		.adc2_done(adc2_done), .adc1_result(adc1_result), .adc2_result(adc2_result));

	////////////////////////////////////////////////////////////////////////
	// 50 ns clock; count converter starts to prove specials skip them
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (adc1_start | adc2_start) starts <= starts + 1;

	task automatic summarize();
		if (fails == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 chk({2'b00, reg_rdata}, {2'b00, exp});
	endtask
	// select, start, wait bounded for done, then judge result and start count
	task automatic conv(input logic m, input logic [7:0] sel, input logic [9:0] exp);
		int n = 0;
		int s0;
		logic spec;
		spec = (sel[3:0] == code_bandgap) || (sel[3:0] == code_ground);
		wr(converter_control_status_b_off, {2'b00, m, 5'h00});
		wr(converter_input_select_off, sel);
		s0 = starts;
		@(posedge sys_clk);
		conv_start <= 1'b1;
		@(posedge sys_clk);
		conv_start <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (conv_done !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			summarize();
		end else begin
			chk(conv_result, exp);
			chk(10'(starts - s0), spec ? 10'h000 : 10'h001);
			chk(10'(n), spec ? 10'h001 : (m ? 10'h006 : 10'h002));
			chk({9'h000, conv_busy}, 10'h001);
			@(posedge sys_clk);
			#1 chk({9'h000, conv_busy}, 10'h000);
		end
	endtask
	// second start while busy must be refused: one start, one result
	task automatic refuse_busy();
		int n = 0;
		int s0;
		wr(converter_control_status_b_off, 8'h20);
		wr(converter_input_select_off, 8'h03);
		s0 = starts;
		@(posedge sys_clk);
		conv_start <= 1'b1;
		@(posedge sys_clk);
		conv_start <= 1'b0;
		@(posedge sys_clk);
		conv_start <= 1'b1;
		@(posedge sys_clk);
		conv_start <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (conv_done !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			summarize();
		end else begin
			chk(conv_result, 10'h283);
			@(posedge sys_clk);
			@(posedge sys_clk);
			#1 chk(10'(starts - s0), 10'h001);
			chk({9'h000, conv_busy}, 10'h000);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(converter_control_status_b_off, 8'h00);
		wr(converter_control_status_b_off, 8'hff);
		rd(converter_control_status_b_off, 8'h20);
		wr(converter_input_select_off, 8'hff);
		rd(converter_input_select_off, 8'hef);
		wr(comparator_control_status_off, 8'hff);
		rd(comparator_control_status_off, 8'h00);
		wr(digital_input_disable_one_off, 8'hff);
		rd(digital_input_disable_one_off, 8'h00);
		rd(converter_control_status_b_off, 8'h20);
		rd(8'h55, 8'h00);
		for (int i = 0; i < 16; i++) begin
			conv(i[3], {5'h00, i[2:0]},
				(i[3] ? 10'h280 : 10'h140) + 10'(i[2:0]));
		end
		conv(1'b0, 8'h08, 10'h140);
		conv(1'b1, 8'h08, 10'h280);
		conv(1'b0, 8'h0e, 10'h155);
		conv(1'b1, 8'h0f, 10'h000);
		refuse_busy();
		summarize();
	end
endmodule // test_dual_adc_channel_select
